// ### rtl/vbir_consts.svh
// Constants of the supply-input event and interrupt-enable register group.
// Assumes an 8-bit register port with a byte offset and single-cycle strobes.
`ifndef VBIR_CONSTS_SVH
`define VBIR_CONSTS_SVH
`define VBIR_OFS_SUP_EVT_SET 8'h16
`define VBIR_OFS_SUP_EVT_CLR 8'h17
`define VBIR_OFS_SUP_IEN_SET 8'h18
`define VBIR_OFS_SUP_IEN_CLR 8'h19
`define VBIR_OFS_THM_EVT_SET 8'h1a
`define VBIR_OFS_THM_EVT_CLR 8'h1b
`define VBIR_OFS_THM_IEN_SET 8'h1c
`define VBIR_OFS_THM_IEN_CLR 8'h1d
`define VBIR_FIELD_MASK      6'h3f
`define VBIR_RESET_VAL       6'h00
`endif

// ### rtl/vbir_pkg.sv
// Types shared by the supply-input event register group.
// Assumes nothing beyond the constants header.
package vbir_pkg;
  typedef logic [5:0] vbir_field_t;
endpackage

// ### rtl/vbir_event_irq_regs.sv
// Supply-input and thermal/config-line event flags with interrupt enables.
// Assumes synchronous monitor levels and a single-cycle register strobe port.
`include "vbir_consts.svh"
module vbir_event_irq_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       input_present,
  input  wire logic       input_overvolt,
  input  wire logic       input_undervolt,
  input  wire logic       heat_warning,
  input  wire logic       heat_cutoff,
  input  wire logic       config_line_one,
  input  wire logic       config_line_two,
  output logic            irq
);
  // Register state, one six-bit field per register pair
  vbir_pkg::vbir_field_t sup_flag_ff;
  vbir_pkg::vbir_field_t thm_flag_ff;
  vbir_pkg::vbir_field_t sup_ien_ff;
  vbir_pkg::vbir_field_t thm_ien_ff;
  logic                  mon_valid_ff;

  // Next values
  vbir_pkg::vbir_field_t nxt_sup_flag;
  vbir_pkg::vbir_field_t nxt_thm_flag;
  vbir_pkg::vbir_field_t nxt_sup_ien;
  vbir_pkg::vbir_field_t nxt_thm_ien;
  logic [7:0]            nxt_reg_rdata;
  logic                  nxt_irq;

  // Write data and decoded write strobes
  vbir_pkg::vbir_field_t wmask;
  logic                  wr_sup_evt_set;
  logic                  wr_sup_evt_clr;
  logic                  wr_sup_ien_set;
  logic                  wr_sup_ien_clr;
  logic                  wr_thm_evt_set;
  logic                  wr_thm_evt_clr;
  logic                  wr_thm_ien_set;
  logic                  wr_thm_ien_clr;

  // Monitor events, one pulse per detected edge
  logic                  input_present_event;
  logic                  input_gone_event;
  logic                  input_overvolt_event;
  logic                  input_overvolt_cleared_event;
  logic                  input_undervolt_event;
  logic                  input_undervolt_cleared_event;
  logic                  heat_warning_event;
  logic                  heat_warning_cleared_event;
  logic                  heat_cutoff_event;
  logic                  heat_cutoff_cleared_event;
  logic                  config_line_one_change_event;
  logic                  config_line_two_change_event;
  vbir_pkg::vbir_field_t sup_hw;
  vbir_pkg::vbir_field_t thm_hw;

  // Flags that currently request an interrupt
  vbir_pkg::vbir_field_t sup_pend;
  vbir_pkg::vbir_field_t thm_pend;

  // Bits 7:6 of the write data never reach a field
  assign wmask = reg_wdata[5:0] & `VBIR_FIELD_MASK;

  // Unmapped offsets match no strobe, so such writes are dropped
  assign wr_sup_evt_set = reg_wr && (reg_addr == `VBIR_OFS_SUP_EVT_SET);
  assign wr_sup_evt_clr = reg_wr && (reg_addr == `VBIR_OFS_SUP_EVT_CLR);
  assign wr_sup_ien_set = reg_wr && (reg_addr == `VBIR_OFS_SUP_IEN_SET);
  assign wr_sup_ien_clr = reg_wr && (reg_addr == `VBIR_OFS_SUP_IEN_CLR);
  assign wr_thm_evt_set = reg_wr && (reg_addr == `VBIR_OFS_THM_EVT_SET);
  assign wr_thm_evt_clr = reg_wr && (reg_addr == `VBIR_OFS_THM_EVT_CLR);
  assign wr_thm_ien_set = reg_wr && (reg_addr == `VBIR_OFS_THM_IEN_SET);
  assign wr_thm_ien_clr = reg_wr && (reg_addr == `VBIR_OFS_THM_IEN_CLR);

  // Edges ignored in the first cycle after reset, while the baseline is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      mon_valid_ff <= 1'h0;
    end else begin
      mon_valid_ff <= 1'h1;
    end
  end

  // Supply input presence
  vbir_edge_det u_det_present (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (input_present),
    .rise   (input_present_event),
    .fall   (input_gone_event),
    .change ()
  );

  // Overvoltage
  vbir_edge_det u_det_overvolt (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (input_overvolt),
    .rise   (input_overvolt_event),
    .fall   (input_overvolt_cleared_event),
    .change ()
  );

  // Undervoltage
  vbir_edge_det u_det_undervolt (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (input_undervolt),
    .rise   (input_undervolt_event),
    .fall   (input_undervolt_cleared_event),
    .change ()
  );

  // Heat warning
  vbir_edge_det u_det_warning (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (heat_warning),
    .rise   (heat_warning_event),
    .fall   (heat_warning_cleared_event),
    .change ()
  );

  // Heat cutoff
  vbir_edge_det u_det_cutoff (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (heat_cutoff),
    .rise   (heat_cutoff_event),
    .fall   (heat_cutoff_cleared_event),
    .change ()
  );

  // Config line one, either direction
  vbir_edge_det u_det_line_one (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (config_line_one),
    .rise   (),
    .fall   (),
    .change (config_line_one_change_event)
  );

  // Config line two, either direction
  vbir_edge_det u_det_line_two (
    .clk    (clk),
    .rst    (rst),
    .arm    (mon_valid_ff),
    .level  (config_line_two),
    .rise   (),
    .fall   (),
    .change (config_line_two_change_event)
  );

  // Supply field order A to F
  always_comb begin
    sup_hw[0] = input_present_event;
    sup_hw[1] = input_gone_event;
    sup_hw[2] = input_overvolt_event;
    sup_hw[3] = input_overvolt_cleared_event;
    sup_hw[4] = input_undervolt_event;
    sup_hw[5] = input_undervolt_cleared_event;
  end

  // Thermal and config-line field order A to F
  always_comb begin
    thm_hw[0] = heat_warning_event;
    thm_hw[1] = heat_warning_cleared_event;
    thm_hw[2] = heat_cutoff_event;
    thm_hw[3] = heat_cutoff_cleared_event;
    thm_hw[4] = config_line_one_change_event;
    thm_hw[5] = config_line_two_change_event;
  end

  // Clear before sets, so a monitor event beats a same-cycle clear
  always_comb begin
    nxt_sup_flag = sup_flag_ff;
    if (wr_sup_evt_clr) begin
      nxt_sup_flag = nxt_sup_flag & ~wmask;
    end
    if (wr_sup_evt_set) begin
      nxt_sup_flag = nxt_sup_flag | wmask;
    end
    nxt_sup_flag = nxt_sup_flag | sup_hw;
  end

  // Same ordering for the thermal group
  always_comb begin
    nxt_thm_flag = thm_flag_ff;
    if (wr_thm_evt_clr) begin
      nxt_thm_flag = nxt_thm_flag & ~wmask;
    end
    if (wr_thm_evt_set) begin
      nxt_thm_flag = nxt_thm_flag | wmask;
    end
    nxt_thm_flag = nxt_thm_flag | thm_hw;
  end

  // Zero bits written leave an enable as it was
  always_comb begin
    nxt_sup_ien = sup_ien_ff;
    if (wr_sup_ien_clr) begin
      nxt_sup_ien = nxt_sup_ien & ~wmask;
    end
    if (wr_sup_ien_set) begin
      nxt_sup_ien = nxt_sup_ien | wmask;
    end
  end

  // Thermal enables
  always_comb begin
    nxt_thm_ien = thm_ien_ff;
    if (wr_thm_ien_clr) begin
      nxt_thm_ien = nxt_thm_ien & ~wmask;
    end
    if (wr_thm_ien_set) begin
      nxt_thm_ien = nxt_thm_ien | wmask;
    end
  end

  // Supply flags
  always_ff @(posedge clk) begin
    if (rst) begin
      sup_flag_ff <= `VBIR_RESET_VAL;
    end else begin
      sup_flag_ff <= nxt_sup_flag;
    end
  end

  // Thermal flags
  always_ff @(posedge clk) begin
    if (rst) begin
      thm_flag_ff <= `VBIR_RESET_VAL;
    end else begin
      thm_flag_ff <= nxt_thm_flag;
    end
  end

  // Supply enables
  always_ff @(posedge clk) begin
    if (rst) begin
      sup_ien_ff <= `VBIR_RESET_VAL;
    end else begin
      sup_ien_ff <= nxt_sup_ien;
    end
  end

  // Thermal enables
  always_ff @(posedge clk) begin
    if (rst) begin
      thm_ien_ff <= `VBIR_RESET_VAL;
    end else begin
      thm_ien_ff <= nxt_thm_ien;
    end
  end

  // From next state, so the request moves at the same edge as its cause
  assign sup_pend = nxt_sup_flag & nxt_sup_ien;
  assign thm_pend = nxt_thm_flag & nxt_thm_ien;
  assign nxt_irq  = |{sup_pend, thm_pend};

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= nxt_irq;
    end
  end

  // A read beside a write returns the value from before the write
  always_comb begin
    nxt_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `VBIR_OFS_SUP_EVT_SET: nxt_reg_rdata = {2'h0, sup_flag_ff};
        `VBIR_OFS_SUP_EVT_CLR: nxt_reg_rdata = {2'h0, sup_flag_ff};
        `VBIR_OFS_SUP_IEN_SET: nxt_reg_rdata = {2'h0, sup_ien_ff};
        `VBIR_OFS_SUP_IEN_CLR: nxt_reg_rdata = {2'h0, sup_ien_ff};
        `VBIR_OFS_THM_EVT_SET: nxt_reg_rdata = {2'h0, thm_flag_ff};
        `VBIR_OFS_THM_EVT_CLR: nxt_reg_rdata = {2'h0, thm_flag_ff};
        `VBIR_OFS_THM_IEN_SET: nxt_reg_rdata = {2'h0, thm_ien_ff};
        `VBIR_OFS_THM_IEN_CLR: nxt_reg_rdata = {2'h0, thm_ien_ff};
        default:               nxt_reg_rdata = 8'h00;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= nxt_reg_rdata;
    end
  end
endmodule

// One monitor level against its baseline: rise, fall and any change.
// Held off by arm until a baseline exists, so reset never fakes an edge.
module vbir_edge_det #(
  parameter logic RESET_LEVEL = 1'h0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic arm,
  input  wire logic level,
  output logic      rise,
  output logic      fall,
  output logic      change
);
  // Level seen at the previous edge
  logic prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= RESET_LEVEL;
    end else begin
      prev_ff <= level;
    end
  end

  always_comb begin
    rise   = 1'h0;
    fall   = 1'h0;
    change = 1'h0;
    if (arm) begin
      rise   = level & ~prev_ff;
      fall   = ~level & prev_ff;
      change = level ^ prev_ff;
    end
  end
endmodule

// ### sim/vbir_regs_checker.sv
// Port assertions for the supply-input event register group.
// Assumes one clock, synchronous active-high reset; bound after the module.
module vbir_regs_checker (
  input wire logic       clk, rst, reg_wr, reg_rd, irq,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       input_present, input_overvolt, input_undervolt,
  input wire logic       heat_warning, heat_cutoff, config_line_one, config_line_two
);
  logic [6:0] mon;
  logic [7:0] wa;
  assign mon = {input_present, input_overvolt, input_undervolt, heat_warning, heat_cutoff,
                config_line_one, config_line_two};
  // Zero when idle so no write offset is ever mistaken for one
  assign wa = reg_wr ? reg_addr : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_HI_ZERO:
    assert property (reg_rd |=> reg_rdata[7:6] == 2'h0) else $error("high bits set");
  AST_UNMAPPED:
    assert property (reg_rd && (reg_addr < 8'h16 || reg_addr > 8'h1d) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  AST_IRQ_RISE:
    assert property ($rose(irq) |-> $past(reg_wr) || $past(mon) != $past(mon, 2))
      else $error("irq rose without cause");
  AST_IRQ_FALL:
    assert property ($fell(irq) |-> $past(reg_wr)) else $error("irq fell without write");
  AST_EN_OFF:
    assert property (wa == 8'h19 && reg_wdata[5:0] == 6'h3f ##1
      wa == 8'h1d && reg_wdata[5:0] == 6'h3f |=> !irq) else $error("irq with enables off");
  AST_SUP_FORCE:
    assert property (wa == 8'h18 && reg_wdata[1] ##1 wa == 8'h16 && reg_wdata[1] |=> irq)
      else $error("forced supply flag gave no irq");
  AST_THM_FORCE:
    assert property (wa == 8'h1c && reg_wdata[3] ##1 wa == 8'h1a && reg_wdata[3] |=> irq)
      else $error("forced thermal flag gave no irq");
  AST_CC_IRQ:
    assert property (wa == 8'h1c && reg_wdata[4] ##1 !reg_wr && $changed(config_line_one)
      |=> irq) else $error("line one change gave no irq");
  cover property (reg_rd ##1 reg_rdata != 8'h00);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind vbir_event_irq_regs vbir_regs_checker u_chk (.*);

// ### sim/tb_vbir_event_irq_regs.sv
// Self-checking bench for the supply-input event register group.
// Assumes the design and its checker are compiled before this file.
module tb_vbir_event_irq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       input_present = 0, input_overvolt = 0, input_undervolt = 0;
  logic       heat_warning = 0, heat_cutoff = 0, config_line_one = 0, config_line_two = 0;
  int         miscompares = 0, n_checks = 0;
  vbir_event_irq_regs u_dut (
    .clk             (clk),
    .rst             (rst),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .input_present   (input_present),
    .input_overvolt  (input_overvolt),
    .input_undervolt (input_undervolt),
    .heat_warning    (heat_warning),
    .heat_cutoff     (heat_cutoff),
    .config_line_one (config_line_one),
    .config_line_two (config_line_two),
    .irq             (irq)
  );
  initial forever #5 clk = ~clk;
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, a, d};
  endtask
  task automatic idle();
    @(negedge clk) {reg_wr, reg_rd} = 2'b00;
  endtask
  task automatic mon(logic [6:0] v);
    @(negedge clk) {input_present, input_overvolt, input_undervolt, heat_warning, heat_cutoff,
      config_line_one, config_line_two} = v;
  endtask
  task automatic chk_rd(logic [7:0] a, logic [7:0] e);
    @(negedge clk) {reg_wr, reg_rd, reg_addr} = {2'b01, a};
    @(negedge clk) reg_rd = 0;
    n_checks++;
    if (reg_rdata !== e) begin
      miscompares++;
      $display("MISMATCH reg 0x%h expected 0x%h seen 0x%h", a, e, reg_rdata);
    end
  endtask
  task automatic chk_irq(logic e);
    n_checks++;
    if (irq !== e) begin
      miscompares++;
      $display("MISMATCH irq expected %b seen %b", e, irq);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset();
    chk_irq(1'b0);
    for (int a = 'h16; a <= 'h1e; a++) chk_rd(8'(a), 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_events();
    mon(7'h7f);
    chk_rd(8'h16, 8'h15);
    chk_rd(8'h1a, 8'h35);
    mon(7'h03);
    chk_rd(8'h16, 8'h3f);
    chk_rd(8'h1a, 8'h3f);
    wr(8'h17, 8'hff);
    chk_rd(8'h17, 8'h00);
    wr(8'h1b, 8'h2a);
    chk_rd(8'h1b, 8'h15);
    $display("t_events done");
  endtask
  task automatic t_irq();
    chk_irq(1'b0);
    wr(8'h1c, 8'h01);
    chk_rd(8'h1d, 8'h01);
    chk_irq(1'b1);
    wr(8'h1d, 8'h01);
    idle();
    chk_irq(1'b0);
    wr(8'h1b, 8'h3f);
    config_line_two = 0;
    chk_rd(8'h1a, 8'h20);
    wr(8'h1c, 8'h08);
    wr(8'h1a, 8'h08);
    idle();
    chk_irq(1'b1);
    chk_rd(8'h1b, 8'h28);
    wr(8'h1b, 8'h3f);
    wr(8'h1d, 8'h3f);
    wr(8'h18, 8'hc2);
    wr(8'h16, 8'h02);
    idle();
    chk_irq(1'b1);
    chk_rd(8'h18, 8'h02);
    wr(8'h17, 8'h02);
    idle();
    chk_irq(1'b0);
    wr(8'h1c, 8'h3f);
    @(negedge clk) {reg_wr, config_line_one} = 2'b00;
    idle();
    chk_irq(1'b1);
    wr(8'h19, 8'h3f);
    wr(8'h1d, 8'h3f);
    idle();
    chk_irq(1'b0);
    chk_rd(8'h1c, 8'h00);
    $display("t_irq done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_reset();
    t_events();
    t_irq();
    close_out();
  end
  initial begin
    #5us;
    miscompares++;
    close_out();
  end
endmodule
